// file: verilog/bct_pkg.sv
// package: register map, field positions and constants of the capacity tracker
`default_nettype none
package bct_pkg;
  // ====================================================================
  // register map (byte addresses)
  localparam logic [7:0] BCT_STATUS_ADDR = 8'h01;
  localparam logic [7:0] BCT_SENSE_ADDR = 8'h69;
  localparam logic [7:0] BCT_CHGV_ADDR = 8'h64;
  localparam logic [7:0] BCT_TERMI_ADDR = 8'h65;
  localparam logic [7:0] BCT_AEV_ADDR = 8'h66;
  localparam logic [7:0] BCT_AEI_ADDR = 8'h67;
  localparam logic [7:0] BCT_WEAR_MSB_ADDR = 8'h62;
  localparam logic [7:0] BCT_WEAR_LSB_ADDR = 8'h63;
  localparam logic [7:0] BCT_AGE_ADDR = 8'h14;
  localparam logic [7:0] BCT_UNMAPPED_DATA = 8'hff;
  // ====================================================================
  // status bit positions
  localparam int BCT_FULL_BIT = 7;
  localparam int BCT_AEF_BIT = 6;
  localparam int BCT_SEF_BIT = 5;
  localparam int BCT_LEARN_BIT = 4;
  localparam int BCT_UV_BIT = 2;
  localparam int BCT_POR_BIT = 1;
  // ====================================================================
  // reset values and limits
  localparam logic [7:0] BCT_AGE_FULL = 8'h80;
  localparam logic [7:0] BCT_AGE_FLOOR = 8'h40;
  localparam logic [7:0] BCT_PARAM_RST = 8'h00;
  localparam logic [15:0] BCT_WEAR_RST = 16'h0000;
  localparam logic [15:0] BCT_POS_MIN_I = 16'h0010;
  localparam logic [7:0] BCT_FULL_CLR_PCT = 8'h5a;
  localparam logic [7:0] BCT_AEF_CLR_PCT = 8'h05;
  localparam logic [7:0] BCT_SEF_SET_PCT = 8'h0a;
  localparam logic [7:0] BCT_SEF_CLR_PCT = 8'h0f;
  localparam int BCT_AGE_MULT_SHIFT = 5;
endpackage : bct_pkg
`default_nettype wire

// file: verilog/bct_tracker.sv
// capacity tracking, learn cycle, aging and status flags of a cell monitor
`default_nettype none
// ======================================================================
// tracker core
module bct_tracker
  import bct_pkg::*;
#(
  parameter int ACC_W = 16
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // measurement results, one pulse per conversion
  input wire logic volt_valid,
  input wire logic [7:0] cell_voltage_input,
  input wire logic below_undervoltage_limit,
  input wire logic curr_valid,
  input wire logic signed [15:0] current_now,
  input wire logic average_current_valid,
  input wire logic signed [15:0] average_current,
  // accumulator and model values
  input wire logic [ACC_W-1:0] coulomb_accumulator,
  input wire logic acc_dec,
  input wire logic [ACC_W-1:0] acc_dec_amt,
  input wire logic [ACC_W-1:0] full_model_scaled,
  input wire logic [ACC_W-1:0] empty_model,
  input wire logic [ACC_W-1:0] learned_capacity,
  input wire logic [ACC_W-1:0] rated_full,
  input wire logic [7:0] remaining_active_percent,
  input wire logic [7:0] remaining_standby_percent,
  input wire logic acc_host_load,
  input wire logic sleep_enter,
  input wire logic nv_age_valid,
  input wire logic [7:0] nv_age,
  // outputs
  output logic acc_load,
  output logic [ACC_W-1:0] acc_load_val,
  output logic age_save,
  output logic [7:0] age_scalar,
  output logic [7:0] sense_conductance,
  output logic [7:0] gauge_status_flags
);
  // ====================================================================
  // synchronise asynchronous flags
  logic uv_s1_r, uv_s2_r, sl_s1_r, sl_s2_r;
  always_ff @(posedge ref_clk) begin
    uv_s1_r <= below_undervoltage_limit;
    uv_s2_r <= uv_s1_r;
    sl_s1_r <= sleep_enter;
    sl_s2_r <= sl_s1_r;
  end

  // ====================================================================
  // parameter registers
  logic [7:0] sense_r, sense_nxt, chgv_r, chgv_nxt, termi_r, termi_nxt;
  logic [7:0] aev_r, aev_nxt, aei_r, aei_nxt, age_r, age_nxt;
  logic [15:0] wear_r, wear_nxt;
  // status flags
  logic full_charge_flag, low_active_flag, standby_low_flag;
  logic learn_window_flag, undervolt_flag, power_up_flag;
  logic [7:0] flags_r, flags_nxt;
  // detection history
  logic [1:0] neg_hist_r, neg_hist_nxt;
  logic [1:0] average_current_ok_r, average_current_ok_nxt;
  logic hi_v_r, hi_v_nxt;
  logic [ACC_W+5:0] dis_cnt_r, dis_cnt_nxt;
  logic acc_load_r, acc_load_nxt, age_save_r, age_save_nxt;
  logic [ACC_W-1:0] acc_val_r, acc_val_nxt;
  logic [7:0] rdata_r, rdata_nxt;

  assign full_charge_flag = flags_r[BCT_FULL_BIT];
  assign low_active_flag = flags_r[BCT_AEF_BIT];
  assign standby_low_flag = flags_r[BCT_SEF_BIT];
  assign learn_window_flag = flags_r[BCT_LEARN_BIT];
  assign undervolt_flag = flags_r[BCT_UV_BIT];
  assign power_up_flag = flags_r[BCT_POR_BIT];

  // ====================================================================
  // next-state logic
  logic full_det, ae_point, neg_now, iae_ok, average_current_ok;
  logic [ACC_W+5:0] age_limit;
  logic [15:0] neg_mag;
  logic [ACC_W+7:0] adj;
  always_comb begin
    sense_nxt = sense_r;
    chgv_nxt = chgv_r;
    termi_nxt = termi_r;
    aev_nxt = aev_r;
    aei_nxt = aei_r;
    wear_nxt = wear_r;
    age_nxt = age_r;
    flags_nxt = flags_r;
    neg_hist_nxt = neg_hist_r;
    average_current_ok_nxt = average_current_ok_r;
    hi_v_nxt = hi_v_r;
    dis_cnt_nxt = dis_cnt_r;
    acc_load_nxt = 1'b0;
    acc_val_nxt = acc_val_r;
    age_save_nxt = 1'b0;
    rdata_nxt = rdata_r;
    full_det = 1'b0;
    ae_point = 1'b0;
    neg_now = current_now[15];
    neg_mag = 16'(-current_now);
    // magnitude vs empty current (byte is 4x coarser than current lsb)
    iae_ok = neg_now && (neg_mag > {6'h00, aei_r, 2'b00});
    // average below termination; positive above 16 lsb
    average_current_ok = !average_current[15] && (average_current > $signed(BCT_POS_MIN_I))
              && (average_current < $signed({8'h00, termi_r}));
    // aging threshold is 32x rating
    // widen before the shift so the top bits of the rating survive
    age_limit = (ACC_W+6)'(wear_r) << BCT_AGE_MULT_SHIFT;
    adj = '0;
    // host writes; flag bits other than uv/por are read only
    if (reg_wr) begin
      unique case (reg_addr)
        BCT_SENSE_ADDR: sense_nxt = reg_wdata;
        BCT_CHGV_ADDR: chgv_nxt = reg_wdata;
        BCT_AEV_ADDR: aev_nxt = reg_wdata;
        BCT_TERMI_ADDR: termi_nxt = reg_wdata;
        BCT_AEI_ADDR: aei_nxt = reg_wdata;
        BCT_WEAR_MSB_ADDR: wear_nxt[15:8] = reg_wdata;
        BCT_WEAR_LSB_ADDR: wear_nxt[7:0] = reg_wdata;
        // host age write, clamped to floor
        BCT_AGE_ADDR: age_nxt = (reg_wdata < BCT_AGE_FLOOR) ? BCT_AGE_FLOOR : reg_wdata;
        BCT_STATUS_ADDR: begin
          // clear only when voltage is back above limit
          if (!reg_wdata[BCT_UV_BIT] && !uv_s2_r) flags_nxt[BCT_UV_BIT] = 1'b0;
          if (!reg_wdata[BCT_POR_BIT]) flags_nxt[BCT_POR_BIT] = 1'b0;
        end
        default: ;
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        BCT_STATUS_ADDR: rdata_nxt = flags_r;
        BCT_SENSE_ADDR: rdata_nxt = sense_r;
        BCT_CHGV_ADDR: rdata_nxt = chgv_r;
        BCT_TERMI_ADDR: rdata_nxt = termi_r;
        BCT_AEV_ADDR: rdata_nxt = aev_r;
        BCT_AEI_ADDR: rdata_nxt = aei_r;
        BCT_WEAR_MSB_ADDR: rdata_nxt = wear_r[15:8];
        BCT_WEAR_LSB_ADDR: rdata_nxt = wear_r[7:0];
        BCT_AGE_ADDR: rdata_nxt = age_r;
        default: rdata_nxt = BCT_UNMAPPED_DATA;
      endcase
    end
    if (nv_age_valid) age_nxt = (nv_age < BCT_AGE_FLOOR) ? BCT_AGE_FLOOR : nv_age;
    // ---- current history
    if (curr_valid) begin
      neg_hist_nxt = {neg_hist_r[0], iae_ok};
      if (neg_now) flags_nxt[BCT_LEARN_BIT] = 1'b0;
    end
    // ---- voltage result
    if (volt_valid) begin
      // voltage must stay above threshold throughout
      if (cell_voltage_input <= chgv_r) begin
        hi_v_nxt = 1'b0;
        average_current_ok_nxt = 2'b00;
      end
      if (cell_voltage_input < aev_r) begin
        // low active flag set on low voltage
        flags_nxt[BCT_AEF_BIT] = 1'b1;
        // active-empty point needs two heavy discharges
        if (&neg_hist_r) ae_point = 1'b1;
      end
    end
    if (average_current_valid) begin
      average_current_ok_nxt = {average_current_ok_r[0], average_current_ok};
      if (hi_v_r && average_current_ok_r[0] && average_current_ok) full_det = 1'b1;
      hi_v_nxt = 1'b1;
    end
    // empty point sets learn and loads empty model
    if (ae_point) begin
      flags_nxt[BCT_LEARN_BIT] = 1'b1;
      acc_load_nxt = 1'b1;
      acc_val_nxt = empty_model;
    end else if (volt_valid && cell_voltage_input < aev_r && !learn_window_flag
                 && coulomb_accumulator > empty_model) begin
      acc_load_nxt = 1'b1;
      acc_val_nxt = empty_model;
    end
    // aging by cumulative discharge
    if (acc_dec) begin
      dis_cnt_nxt = dis_cnt_r + (ACC_W+6)'(acc_dec_amt);
      if (wear_r != BCT_WEAR_RST && dis_cnt_nxt >= age_limit) begin
        dis_cnt_nxt = '0;
        if (age_nxt > BCT_AGE_FLOOR) age_nxt = age_nxt - 8'h01;
        age_save_nxt = 1'b1;
      end
    end
    // full detection
    if (full_det) begin
      flags_nxt[BCT_FULL_BIT] = 1'b1;
      if (learn_window_flag) begin
        // age from learned capacity, ratio in 2^-7 units
        if (rated_full != '0)
          adj = (ACC_W+8)'(({8'h00, learned_capacity} << 7) / {8'h00, rated_full});
        age_nxt = (adj > (ACC_W+8)'(BCT_AGE_FULL)) ? BCT_AGE_FULL :
                  (adj < (ACC_W+8)'(BCT_AGE_FLOOR)) ? BCT_AGE_FLOOR : adj[7:0];
        age_save_nxt = 1'b1;
        // learn ends when full is reached
        flags_nxt[BCT_LEARN_BIT] = 1'b0;
      end
      // scaled full value, loaded in the same cycle as any age update
      acc_load_nxt = 1'b1;
      acc_val_nxt = full_model_scaled;
    end
    if (remaining_active_percent < BCT_FULL_CLR_PCT && !full_det)
      flags_nxt[BCT_FULL_BIT] = 1'b0;
    // clear low active above 5 percent
    if (remaining_active_percent > BCT_AEF_CLR_PCT && !(volt_valid && cell_voltage_input < aev_r))
      flags_nxt[BCT_AEF_BIT] = 1'b0;
    if (remaining_standby_percent < BCT_SEF_SET_PCT) flags_nxt[BCT_SEF_BIT] = 1'b1;
    else if (remaining_standby_percent > BCT_SEF_CLR_PCT) flags_nxt[BCT_SEF_BIT] = 1'b0;
    if (coulomb_accumulator == '0 || acc_host_load || sl_s2_r)
      flags_nxt[BCT_LEARN_BIT] = 1'b0;
    // undervoltage sets, wins over host clear
    if (uv_s2_r) flags_nxt[BCT_UV_BIT] = 1'b1;
    flags_nxt[3] = 1'b0;
    flags_nxt[0] = 1'b0;
  end

  // ====================================================================
  // registers
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sense_r <= BCT_PARAM_RST;
      chgv_r <= BCT_PARAM_RST;
      termi_r <= BCT_PARAM_RST;
      aev_r <= BCT_PARAM_RST;
      aei_r <= BCT_PARAM_RST;
      wear_r <= BCT_WEAR_RST;
      age_r <= BCT_AGE_FULL;
      flags_r <= 8'h06;
      neg_hist_r <= 2'b00;
      average_current_ok_r <= 2'b00;
      hi_v_r <= 1'b0;
      dis_cnt_r <= '0;
      acc_load_r <= 1'b0;
      acc_val_r <= '0;
      age_save_r <= 1'b0;
      rdata_r <= 8'h00;
    end else begin
      sense_r <= sense_nxt;
      chgv_r <= chgv_nxt;
      termi_r <= termi_nxt;
      aev_r <= aev_nxt;
      aei_r <= aei_nxt;
      wear_r <= wear_nxt;
      age_r <= age_nxt;
      flags_r <= flags_nxt;
      neg_hist_r <= neg_hist_nxt;
      average_current_ok_r <= average_current_ok_nxt;
      hi_v_r <= hi_v_nxt;
      dis_cnt_r <= dis_cnt_nxt;
      acc_load_r <= acc_load_nxt;
      acc_val_r <= acc_val_nxt;
      age_save_r <= age_save_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign acc_load = acc_load_r;
  assign acc_load_val = acc_val_r;
  assign age_save = age_save_r;
  assign age_scalar = age_r;
  assign sense_conductance = sense_r;
  assign gauge_status_flags = flags_r;
  assign reg_rdata = rdata_r;
endmodule // bct_tracker
`default_nettype wire

// file: bench/bct_tracker_asserts.sv
// checker: port assertions of the capacity tracker
`default_nettype none
module bct_tracker_asserts
  import bct_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // causes
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic curr_valid,
  input wire logic volt_valid,
  input wire logic signed [15:0] current_now,
  input wire logic [7:0] remaining_active_percent,
  input wire logic [7:0] remaining_standby_percent,
  // effects
  input wire logic acc_load,
  input wire logic [7:0] age_scalar,
  input wire logic [7:0] sense_conductance,
  input wire logic [7:0] gauge_status_flags
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  // ==================================================================
  // assertions
  chk_reset_flags: assert property ($fell(reset) |->
    gauge_status_flags == 8'h06 && age_scalar == BCT_AGE_FULL) else $error("reset values");
  chk_rsvd_zero: assert property (gauge_status_flags[3] == 1'b0 &&
    gauge_status_flags[0] == 1'b0) else $error("reserved bits set");
  chk_age_floor: assert property (age_scalar >= BCT_AGE_FLOOR)
    else $error("age below floor");
  chk_full_load: assert property ($rose(gauge_status_flags[BCT_FULL_BIT])
    |-> ##[0:2] acc_load) else $error("no load on full");
  chk_load_pulse: assert property (acc_load |=> !acc_load) else $error("load not a pulse");
  chk_por_sticky: assert property (gauge_status_flags[BCT_POR_BIT] && !reg_wr
    |=> gauge_status_flags[BCT_POR_BIT]) else $error("power-up flag lost");
  chk_uv_sticky: assert property (gauge_status_flags[BCT_UV_BIT] && !reg_wr
    |=> gauge_status_flags[BCT_UV_BIT]) else $error("undervolt flag lost");
  chk_full_clear: assert property ($fell(gauge_status_flags[BCT_FULL_BIT])
    |-> $past(remaining_active_percent) < BCT_FULL_CLR_PCT) else $error("full cleared early");
  chk_learn_neg: assert property (gauge_status_flags[BCT_LEARN_BIT] && curr_valid
    && current_now < 0 && !volt_valid |=> !gauge_status_flags[BCT_LEARN_BIT])
    else $error("learn kept on discharge");
  chk_sef_set: assert property (remaining_standby_percent < BCT_SEF_SET_PCT
    |-> ##[1:3] gauge_status_flags[BCT_SEF_BIT]) else $error("standby flag not set");
  chk_sense_hold: assert property (!(reg_wr && reg_addr == BCT_SENSE_ADDR)
    |=> $stable(sense_conductance)) else $error("sense byte changed");
endmodule // bct_tracker_asserts
bind bct_tracker bct_tracker_asserts chk_u (.*);
`default_nettype wire

// file: bench/bct_host_model.sv
// host model: register master facing the tracker
`default_nettype none
module bct_host_model
  import bct_pkg::*;
(
  // clock
  input wire logic ref_clk,
  // register port
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
  end
  // ==================================================================
  // age written only when asked
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    // idle bus shows inverted values, never stale ones
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  task automatic clear_sticky();
    access(1'b1, BCT_STATUS_ADDR, 8'h00);
  endtask
endmodule // bct_host_model
`default_nettype wire

// file: bench/bct_tracker_bench.sv
// testbench: capacity tracker through its register port
`default_nettype none
module bct_tracker_bench
  import bct_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, reset, reg_wr, reg_rd, volt_valid, below_undervoltage_limit, curr_valid;
  logic average_current_valid, acc_dec, acc_host_load, sleep_enter, nv_age_valid, acc_load, age_save;
  logic rd_d = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, cell_voltage_input, nv_age, age_scalar;
  logic [7:0] remaining_active_percent, remaining_standby_percent;
  logic [7:0] sense_conductance, gauge_status_flags;
  logic signed [15:0] current_now, average_current;
  logic [15:0] coulomb_accumulator, acc_dec_amt, full_model_scaled, empty_model;
  logic [15:0] learned_capacity, rated_full, acc_load_val, exp_v;
  logic [31:0] lf;
  logic [15:0] exp_q[$];
  logic [7:0] adr[7] = '{BCT_CHGV_ADDR, BCT_TERMI_ADDR, BCT_AEV_ADDR, BCT_AEI_ADDR,
    BCT_WEAR_MSB_ADDR, BCT_WEAR_LSB_ADDR, BCT_SENSE_ADDR};
  logic [7:0] sb[4] = '{8'h09, 8'h0c, 8'h10, 8'h0c};
  logic [7:0] sbx[4] = '{8'h20, 8'h20, 8'h00, 8'h00};
  int err_total, checks_done, n;
  bct_tracker dut_u (.*);
  bct_host_model host_u (.*);
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // ==================================================================
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host_u.access(1'b1, a, d);
  endtask
  // slack lets slow flag updates settle before the read
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    repeat (2) @(posedge ref_clk);
    exp_q.push_back({8'h00, e});
    host_u.access(1'b0, a, 8'h00);
  endtask
  // k: 0 voltage, 1 current, 2 average, 3 discharge, 4 host load, 5 restore
  task automatic meas(input int k, input logic [15:0] v);
    @(posedge ref_clk);
    {cell_voltage_input, nv_age, current_now, average_current} <= {v[7:0], v[7:0], v, v};
    {volt_valid, curr_valid, average_current_valid} <= {k == 0, k == 1, k == 2};
    {acc_dec, acc_host_load, nv_age_valid} <= {k == 3, k == 4, k == 5};
    @(posedge ref_clk);
    {volt_valid, curr_valid, average_current_valid, acc_dec, acc_host_load, nv_age_valid} <= 6'h00;
  endtask
  task automatic wait_load(input logic [15:0] e);
    n = 0;
    #1;
    while (acc_load !== 1'b1 && n < 10) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    if (n == 10) begin
      err_total++;
      print_verdict();
    end
    check("acc_load_val", acc_load_val, e);
  endtask
  // ==================================================================
  // read results checked in order of issue
  always @(posedge ref_clk) begin
    rd_d <= reg_rd;
    if (rd_d === 1'b1) begin
      exp_v = exp_q.pop_front();
      check("reg_rdata", {8'h00, reg_rdata}, exp_v);
    end
  end
  // ==================================================================
  // main sequence
  initial begin
    {reset, below_undervoltage_limit, sleep_enter} = 3'h4;
    {volt_valid, curr_valid, average_current_valid, acc_dec, acc_host_load, nv_age_valid} = 6'h00;
    {cell_voltage_input, nv_age, current_now, average_current} = '0;
    {remaining_active_percent, remaining_standby_percent} = 16'h3232;
    {coulomb_accumulator, acc_dec_amt} = 32'h1234_0001;
    lf = lfsr(32'h03afff7d);
    {full_model_scaled, empty_model} = lf;
    lf = lfsr(lf);
    {learned_capacity, rated_full} = lf | 32'h0001_0001;
    {err_total, checks_done} = '0;
    repeat (4) @(posedge ref_clk);
    reset <= 1'b0;
    rd(BCT_STATUS_ADDR, 8'h06);
    rd(BCT_AGE_ADDR, BCT_AGE_FULL);
    rd(8'h00, BCT_UNMAPPED_DATA);
    foreach (adr[i]) begin
      lf = lfsr(lf);
      wr(adr[i], lf[7:0]);
      rd(adr[i], lf[7:0]);
    end
    check("sense", {8'h00, sense_conductance}, {8'h00, lf[7:0]});
    $display("reset and parameters done");
    below_undervoltage_limit <= 1'b1;
    repeat (4) @(posedge ref_clk);
    host_u.clear_sticky();
    rd(BCT_STATUS_ADDR, 8'h04);
    wr(BCT_STATUS_ADDR, 8'hff);
    rd(BCT_STATUS_ADDR, 8'h04);
    below_undervoltage_limit <= 1'b0;
    repeat (4) @(posedge ref_clk);
    host_u.clear_sticky();
    rd(BCT_STATUS_ADDR, 8'h00);
    wr(BCT_AGE_ADDR, 8'h20);
    rd(BCT_AGE_ADDR, BCT_AGE_FLOOR);
    meas(5, 16'h0070);
    rd(BCT_AGE_ADDR, 8'h70);
    $display("sticky flags and age done");
    wr(BCT_WEAR_MSB_ADDR, 8'h00);
    wr(BCT_WEAR_LSB_ADDR, 8'h01);
    for (int i = 1; i <= 64; i++) begin
      meas(3, 16'h0001);
      if (i == 31) rd(BCT_AGE_ADDR, 8'h70);
      if (i == 32) rd(BCT_AGE_ADDR, 8'h6f);
      if (i == 64) rd(BCT_AGE_ADDR, 8'h6e);
    end
    wr(BCT_AGE_ADDR, 8'h41);
    repeat (64) meas(3, 16'h0001);
    rd(BCT_AGE_ADDR, BCT_AGE_FLOOR);
    $display("aging done");
    wr(BCT_CHGV_ADDR, 8'h80);
    wr(BCT_TERMI_ADDR, 8'hff);
    wr(BCT_AEV_ADDR, 8'h80);
    remaining_active_percent <= 8'h64;
    // first pair sits on the 16-count minimum and must not qualify
    for (int i = 0; i < 4; i++) begin
      meas(0, 16'h00c0);
      meas(2, (i < 2) ? 16'h0010 : 16'h0011);
      if (i == 1) rd(BCT_STATUS_ADDR, 8'h00);
    end
    wait_load(full_model_scaled);
    rd(BCT_STATUS_ADDR, 8'h80);
    remaining_active_percent <= 8'h59;
    rd(BCT_STATUS_ADDR, 8'h00);
    $display("full detect done");
    wr(BCT_AEI_ADDR, 8'h01);
    remaining_active_percent <= 8'h03;
    meas(1, 16'hff9c);
    meas(1, 16'hff9c);
    meas(0, 16'h0010);
    wait_load(empty_model);
    rd(BCT_STATUS_ADDR, 8'h50);
    meas(4, 16'h0000);
    rd(BCT_STATUS_ADDR, 8'h40);
    remaining_active_percent <= 8'h06;
    rd(BCT_STATUS_ADDR, 8'h00);
    foreach (sb[i]) begin
      remaining_standby_percent <= sb[i];
      rd(BCT_STATUS_ADDR, sbx[i]);
    end
    $display("empty and standby done");
    // learn cycle: empty point, then full with the learn flag up
    meas(1, 16'hff9c);
    meas(1, 16'hff9c);
    meas(0, 16'h0010);
    wait_load(empty_model);
    remaining_active_percent <= 8'h64;
    repeat (2) begin
      meas(0, 16'h00c0);
      meas(2, 16'h0011);
    end
    wait_load(full_model_scaled);
    rd(BCT_STATUS_ADDR, 8'h80);
    n = (int'(learned_capacity) * 128) / int'(rated_full);
    rd(BCT_AGE_ADDR, (n > 128) ? BCT_AGE_FULL : (n < 64) ? BCT_AGE_FLOOR : 8'(n));
    $display("learn cycle done");
    n = 0;
    while (exp_q.size() > 0 && n < 20) begin
      @(posedge ref_clk);
      n++;
    end
    if (exp_q.size() > 0) err_total++;
    print_verdict();
  end
endmodule // bct_tracker_bench
`default_nettype wire
